// *** pkg/sase_pkg.sv ***
// sase_pkg: constants, layouts and carrier types of the skip-and-subtract execution slice
// assumes one 250 MHz clock and a 32-bit Avalon-MM register port with byte addresses
package sase_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and sizes
  localparam int CLK_PERIOD_NS = 4; // machine cycle is one clock at 250 MHz
  localparam int DATA_W = 8; // accumulator and memory byte width
  localparam int MEM_DEPTH = 88; // data memory bytes
  localparam int MEM_AW = 7; // data memory address width
  localparam int BUS_AW = 5; // avalon byte address width

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [BUS_AW-1:0] OFS_INSTR = 5'h00; // issue an instruction, read last one
  localparam logic [BUS_AW-1:0] OFS_ACC = 5'h04; // accumulator
  localparam logic [BUS_AW-1:0] OFS_FLAGS = 5'h08; // status flags
  localparam logic [BUS_AW-1:0] OFS_STATUS = 5'h0C; // busy, skip pending, skip count
  localparam logic [BUS_AW-1:0] OFS_MEM_ADDR = 5'h10; // data memory pointer for software
  localparam logic [BUS_AW-1:0] OFS_MEM_DATA = 5'h14; // data memory byte at the pointer

  ////////////////////////////////////////////////////////////////////////////
  // instruction word field positions
  localparam int INSTR_IMM_LSB = 0; // immediate byte [7:0]
  localparam int INSTR_ADDR_LSB = 8; // memory address [14:8]
  localparam int INSTR_BIT_LSB = 16; // bit select [18:16]
  localparam int INSTR_OP_LSB = 20; // operation [22:20]

  // flag register bit positions
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_AC_BIT = 1;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_OV_BIT = 3;

  // status register bit positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SKIP_BIT = 1;
  localparam int STAT_CNT_LSB = 8;

  // reset values
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] MEM_ADDR_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // operations
  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_INCREMENT_MEMORY_SKIP_ZERO = 3'b001,
    OP_INCREMENT_TO_ACCUMULATOR_SKIP_ZERO = 3'b010,
    OP_SKIP_WHEN_BIT_SET = 3'b011,
    OP_DIFFERENCE_INTO_ACC = 3'b100,
    OP_DIFFERENCE_INTO_MEMORY = 3'b101,
    OP_DIFFERENCE_IMMEDIATE = 3'b110,
    OP_RESERVED = 3'b111
  } sase_op_type;

  // executor states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_EXEC = 3'b010,
    ST_DUMMY = 3'b011,
    ST_SQUASH = 3'b100
  } sase_state_type;

  // decoded instruction
  typedef struct packed {
    sase_op_type op;
    logic [2:0] bit_sel;
    logic [MEM_AW-1:0] addr;
    logic [DATA_W-1:0] imm;
  } sase_instr_type;

  // arithmetic flags
  typedef struct packed {
    logic overflow_flag;
    logic z;
    logic auxiliary_carry_flag;
    logic c;
  } sase_flags_type;

endpackage : sase_pkg

// *** rtl/sase_data_mem.sv ***
// sase_data_mem: single-port data memory with registered read data
// assumes one clock; out-of-range addresses read zero and ignore writes
`timescale 1ns/1ps
module sase_data_mem #(
  parameter int DEPTH = sase_pkg::MEM_DEPTH,
  parameter int AW = sase_pkg::MEM_AW,
  parameter int DW = sase_pkg::DATA_W
) (
  input wire logic clk_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic we_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  import sase_pkg::*;

  logic [DW-1:0] mem_q [DEPTH]; // storage, no reset like a real ram
  logic in_range; // address inside the array

  assign in_range = (32'(addr_i) < DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // write port
  always_ff @(posedge clk_i) begin
    if (we_i && in_range) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  // read port, old data on a same-cycle write
  always_ff @(posedge clk_i) begin
    if (in_range) begin
      rdata_o <= mem_q[addr_i];
    end else begin
      rdata_o <= '0; // holes read as zero
    end
  end

endmodule : sase_data_mem

// *** rtl/sase_sub_alu.sv ***
// sase_sub_alu: eight-bit subtractor with overflow, zero, half and full carry
// assumes purely combinational use by the executor
`timescale 1ns/1ps
module sase_sub_alu #(
  parameter int DW = sase_pkg::DATA_W
) (
  input wire logic [DW-1:0] minuend_i,
  input wire logic [DW-1:0] subtrahend_i,
  output logic [DW-1:0] diff_o,
  output sase_pkg::sase_flags_type flags_o
);
  import sase_pkg::*;

  logic [DW:0] wide; // difference with borrow in the top bit
  logic [4:0] low; // low nibble difference with borrow

  ////////////////////////////////////////////////////////////////////////////
  // carry means no borrow, so a negative result clears it
  always_comb begin
    wide = {1'b0, minuend_i} - {1'b0, subtrahend_i};
    low = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]};
    diff_o = wide[DW-1:0];
    flags_o.c = ~wide[DW];
    flags_o.auxiliary_carry_flag = ~low[4];
    flags_o.z = (wide[DW-1:0] == '0);
    flags_o.overflow_flag = (minuend_i[DW-1] != subtrahend_i[DW-1]) && (wide[DW-1] != minuend_i[DW-1]);
  end

endmodule : sase_sub_alu

// *** rtl/sase_exec.sv ***
// sase_exec: executes the increment-skip, bit-skip and subtract instructions
// assumes an avalon-mm master on the same clock issues instructions through the register port
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module sase_exec (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [sase_pkg::BUS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic busy_o
);
  import sase_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  sase_state_type state_q; // executor state
  sase_state_type state_d;
  sase_instr_type instr_q; // instruction being executed
  logic [31:0] instr_word_q; // last instruction word as written
  logic [DATA_W-1:0] acc_q; // accumulator
  sase_flags_type flags_q; // arithmetic flags
  logic skip_pend_q; // next issued instruction is to be dropped
  logic [7:0] skip_cnt_q; // dropped instructions, wraps
  logic [MEM_AW-1:0] mem_ptr_q; // software memory pointer
  logic rd_pend_q; // memory read by software in flight
  logic wait_q; // waitrequest register

  logic req; // master presents a request
  logic needs_idle; // access that conflicts with execution
  logic accept; // request taken this cycle
  logic issue; // accepted write to the instruction register
  logic [31:0] merged; // write data merged under byte enables
  logic [31:0] rd_mux; // read data of register accesses

  logic [MEM_AW-1:0] mem_addr; // memory port address
  logic mem_we; // memory port write
  logic [DATA_W-1:0] mem_wdata; // memory port write data
  logic [DATA_W-1:0] mem_rdata; // registered memory read data

  logic [DATA_W-1:0] sub_b; // subtrahend: memory or immediate
  logic [DATA_W-1:0] diff; // subtractor result
  sase_flags_type sub_flags; // subtractor flags
  logic [DATA_W-1:0] inc_val; // memory byte plus one
  logic skip_now; // current instruction skips its successor

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge of a write with the old register value
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_be

  ////////////////////////////////////////////////////////////////////////////
  // bus request decode
  // writes to instr, acc and flags and all memory data accesses wait while an instruction runs, so software
  // never races the executor for the accumulator, flags or memory port
  // reads of acc, flags and status pass while busy and show the state of
  // the instruction in flight; software polls busy before trusting them
  always_comb begin
    req = avs_read_i || avs_write_i;
    needs_idle = (avs_write_i && (avs_address_i == OFS_INSTR || avs_address_i == OFS_ACC ||
                                  avs_address_i == OFS_FLAGS)) ||
                 (avs_address_i == OFS_MEM_DATA);
    accept = req && wait_q && !rd_pend_q && !(needs_idle && state_q != ST_IDLE);
    issue = accept && avs_write_i && (avs_address_i == OFS_INSTR);
  end

  // read multiplexer and write merge source
  always_comb begin
    rd_mux = 32'h0000_0000; // unmapped reads give zero
    case (avs_address_i)
      OFS_INSTR: rd_mux = instr_word_q;
      OFS_ACC: rd_mux = {24'h00_0000, acc_q};
      OFS_FLAGS: rd_mux = {28'h000_0000, flags_q};
      OFS_STATUS: begin
        rd_mux[STAT_BUSY_BIT] = (state_q != ST_IDLE);
        rd_mux[STAT_SKIP_BIT] = skip_pend_q;
        rd_mux[STAT_CNT_LSB +: 8] = skip_cnt_q;
      end
      OFS_MEM_ADDR: rd_mux = {25'h000_0000, mem_ptr_q};
      default: rd_mux = 32'h0000_0000;
    endcase
    merged = merge_be(rd_mux, avs_writedata_i, avs_byteenable_i);
  end

  ////////////////////////////////////////////////////////////////////////////
  // waitrequest and read data: answer one edge after acceptance,
  // two edges for a memory read because the ram output is registered
  // the extra cycle matters: answering one edge early would hand back
  // the byte of whatever address the ram saw before the pointer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q <= 1'b1;
      rd_pend_q <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      // ram data for the pointer captured last edge
      rd_pend_q <= 1'b0;
      wait_q <= 1'b0;
      avs_readdata_o <= {24'h00_0000, mem_rdata};
    end else if (accept && avs_read_i && avs_address_i == OFS_MEM_DATA) begin
      rd_pend_q <= 1'b1; // hold the master one more cycle
    end else if (accept) begin
      wait_q <= 1'b0;
      avs_readdata_o <= rd_mux;
    end else begin
      wait_q <= 1'b1; // completion seen, back to stalling
    end
  end

  assign avs_waitrequest_o = wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // software memory pointer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_ptr_q <= MEM_ADDR_RESET[MEM_AW-1:0];
    end else if (accept && avs_write_i && avs_address_i == OFS_MEM_ADDR) begin
      mem_ptr_q <= merged[MEM_AW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath
  assign sub_b = (instr_q.op == OP_DIFFERENCE_IMMEDIATE) ? instr_q.imm : mem_rdata;
  assign inc_val = mem_rdata + 8'h01;

  sase_sub_alu #(
    .DW(DATA_W)
  ) u_alu (
    .minuend_i(acc_q),
    .subtrahend_i(sub_b),
    .diff_o(diff),
    .flags_o(sub_flags)
  );

  // skip decision of the instruction in execute
  always_comb begin
    case (instr_q.op)
      OP_INCREMENT_MEMORY_SKIP_ZERO: skip_now = (inc_val == 8'h00);
      OP_INCREMENT_TO_ACCUMULATOR_SKIP_ZERO: skip_now = (inc_val == 8'h00);
      OP_SKIP_WHEN_BIT_SET: skip_now = mem_rdata[instr_q.bit_sel];
      default: skip_now = 1'b0;
    endcase
  end

  // memory port: executor owns it while busy, software while idle
  always_comb begin
    mem_addr = mem_ptr_q;
    mem_we = 1'b0;
    mem_wdata = merged[DATA_W-1:0];
    if (state_q == ST_FETCH) begin
      mem_addr = instr_q.addr; // operand read
    end else if (state_q == ST_EXEC) begin
      mem_addr = instr_q.addr;
      case (instr_q.op)
        OP_INCREMENT_MEMORY_SKIP_ZERO: begin
          mem_we = 1'b1; // write back the incremented byte
          mem_wdata = inc_val;
        end
        OP_DIFFERENCE_INTO_MEMORY: begin
          mem_we = 1'b1; // difference replaces the operand
          mem_wdata = diff;
        end
        default: mem_we = 1'b0; // other ops leave memory alone
      endcase
    end else if (state_q == ST_IDLE) begin
      mem_we = accept && avs_write_i && (avs_address_i == OFS_MEM_DATA) && avs_byteenable_i[0];
    end
  end

  sase_data_mem #(
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW),
    .DW(DATA_W)
  ) u_mem (
    .clk_i(clk_i),
    .addr_i(mem_addr),
    .we_i(mem_we),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // executor state machine
  // fetch reads the operand, exec writes results; no forwarding needed
  // because a new issue always waits for the idle state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (issue) begin
          // a pending skip turns this instruction into a squash
          state_d = skip_pend_q ? ST_SQUASH : ST_FETCH;
        end
      end
      ST_FETCH: state_d = ST_EXEC;
      ST_EXEC: state_d = skip_now ? ST_DUMMY : ST_IDLE;
      ST_DUMMY: state_d = ST_IDLE; // third machine cycle of a taken skip
      ST_SQUASH: state_d = ST_IDLE; // dropped instruction, no effect
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      busy_o <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_o <= (state_d != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction latch; the raw word reads back even when squashed
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      instr_q <= '0;
      instr_word_q <= 32'h0000_0000;
    end else if (issue) begin
      instr_word_q <= merged;
      if (!skip_pend_q) begin
        instr_q.op <= sase_op_type'(merged[INSTR_OP_LSB +: 3]);
        instr_q.bit_sel <= merged[INSTR_BIT_LSB +: 3];
        instr_q.addr <= merged[INSTR_ADDR_LSB +: MEM_AW];
        instr_q.imm <= merged[INSTR_IMM_LSB +: DATA_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // skip bookkeeping: the flag is raised by a taken skip and consumed by
  // the next issue; both cannot meet since issue needs the idle state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      skip_pend_q <= 1'b0;
      skip_cnt_q <= 8'h00;
    end else if (state_q == ST_EXEC && skip_now) begin
      skip_pend_q <= 1'b1;
    end else if (issue && skip_pend_q) begin
      skip_pend_q <= 1'b0;
      skip_cnt_q <= skip_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_q <= ACC_RESET;
    end else if (state_q == ST_EXEC) begin
      case (instr_q.op)
        OP_INCREMENT_TO_ACCUMULATOR_SKIP_ZERO: acc_q <= inc_val;
        OP_DIFFERENCE_INTO_ACC: acc_q <= diff;
        OP_DIFFERENCE_IMMEDIATE: acc_q <= diff;
        default: acc_q <= acc_q; // memory-result ops keep it
      endcase
    end else if (accept && avs_write_i && avs_address_i == OFS_ACC) begin
      acc_q <= merged[DATA_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: only the three subtract forms and software writes touch them, skips never do
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_q <= '0;
    end else if (state_q == ST_EXEC) begin
      case (instr_q.op)
        OP_DIFFERENCE_INTO_ACC: flags_q <= sub_flags;
        OP_DIFFERENCE_INTO_MEMORY: flags_q <= sub_flags;
        OP_DIFFERENCE_IMMEDIATE: flags_q <= sub_flags;
        default: flags_q <= flags_q;
      endcase
    end else if (accept && avs_write_i && avs_address_i == OFS_FLAGS) begin
      flags_q <= merged[3:0]; // preload for tests of later code
    end
  end

endmodule : sase_exec

// *** testbench/sase_exec_monitor.sv ***
// sase_exec_monitor: port-level checks of the skip-and-subtract executor
// assumes it is bound to sase_exec and that the master keeps the avalon hold rules
`timescale 1ns/1ps
module sase_exec_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [sase_pkg::BUS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic busy_o
);
  import sase_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////////
  // helper logic
  logic instr_done; // instruction write being answered
  logic [1:0] run_q; // busy cycles seen so far, saturating
  logic pend_q; // a three-cycle run means a skip is owed
  assign instr_done = avs_write_i && avs_address_i == OFS_INSTR && !avs_waitrequest_o;

  // length of the current busy run
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) run_q <= 2'h0;
    else if (!busy_o) run_q <= 2'h0;
    else if (run_q != 2'h3) run_q <= run_q + 2'h1;
  end

  // skip owed until the next instruction is answered
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) pend_q <= 1'b0;
    else if (busy_o && run_q == 2'h2) pend_q <= 1'b1;
    else if (instr_done) pend_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // properties
  sequence s_fetch_exec;
    busy_o [*2];
  endsequence
  property p_plain_len;
    instr_done && !pend_q && avs_writedata_i[22:20] inside {3'h0, 3'h4, 3'h5, 3'h6, 3'h7} |-> s_fetch_exec ##1 !busy_o;
  endproperty
  a_plain_len: assert property (p_plain_len) else $error("plain op not two cycles");
  property p_skip_len;
    instr_done && !pend_q |-> s_fetch_exec ##2 !busy_o;
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("op not two or three cycles");
  property p_squash;
    instr_done && pend_q |-> busy_o ##1 !busy_o;
  endproperty
  a_squash: assert property (p_squash) else $error("dropped op not one cycle");
  property p_busy_max;
    $rose(busy_o) |-> ##[1:3] !busy_o;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy run too long");
  property p_wait_pulse;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low twice");
  property p_wait_cause;
    !avs_waitrequest_o |-> avs_read_i || avs_write_i;
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_memrd_lat;
    avs_read_i && avs_address_i == OFS_MEM_DATA && !avs_waitrequest_o |-> $past(avs_waitrequest_o) && $past(avs_read_i, 2);
  endproperty
  a_memrd_lat: assert property (p_memrd_lat) else $error("memory read answered early");
  property p_unmapped;
    avs_read_i && avs_address_i > OFS_MEM_DATA && !avs_waitrequest_o |-> avs_readdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_acc_idle;
    avs_write_i && avs_address_i == OFS_ACC && !avs_waitrequest_o |-> !$past(busy_o);
  endproperty
  a_acc_idle: assert property (p_acc_idle) else $error("acc written while busy");
endmodule : sase_exec_monitor

bind sase_exec sase_exec_monitor u_monitor (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));

// *** testbench/test_skip_and_subtract_exec.sv ***
// test_skip_and_subtract_exec: register-level test of the executor
// assumes sase_exec with its avalon port; all lanes enabled on every write
`timescale 1ns/1ps
module test_skip_and_subtract_exec;
  import sase_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [BUS_AW-1:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic busy_o;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc_q = 0; // watchdog
  int n_d; // busy cycles of the last instruction
  logic [31:0] rd_d; // last read data
  logic [7:0] ca [5] = '{8'h50, 8'h30, 8'h40, 8'h80, 8'h13}; // minuends
  logic [7:0] cb [5] = '{8'h30, 8'h50, 8'h40, 8'h01, 8'h04}; // subtrahends
  logic [7:0] bit_pat = 8'h5A; // mixed byte under the bit test

  always #2 clk_i = ~clk_i;

  sase_exec dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));

  ////////////////////////////////////////////////////////////////////////////
  // report and compare
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////
  // avalon access: hold until waitrequest is sampled low
  task bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd_d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task rd_chk(input logic [BUS_AW-1:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(rd_d, exp, what);
  endtask : rd_chk

  task set_mem(input logic [6:0] a, input logic [7:0] v);
    bus(1'b1, OFS_MEM_ADDR, {25'h0, a});
    bus(1'b1, OFS_MEM_DATA, {24'h0, v});
  endtask : set_mem

  task mem_chk(input logic [6:0] a, input logic [7:0] v, input string what);
    bus(1'b1, OFS_MEM_ADDR, {25'h0, a});
    rd_chk(OFS_MEM_DATA, {24'h0, v}, what);
  endtask : mem_chk

  // issue one instruction and count its busy cycles
  task issue(input logic [2:0] op, input logic [2:0] b, input logic [6:0] a, input logic [7:0] imm);
    bus(1'b1, OFS_INSTR, {9'h000, op, 1'b0, b, 1'b0, a, imm});
    n_d = 0;
    while (busy_o === 1'b1 && n_d < 20) begin
      n_d++;
      @(posedge clk_i);
    end
  endtask : issue

  // one subtract with expected flags {ov, z, ac, c}
  task sub_case(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    logic [31:0] fl;
    d = a - b;
    fl = {28'h0, (a[7] != b[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= b[3:0], a >= b};
    bus(1'b1, OFS_ACC, {24'h0, a});
    set_mem(7'h20, b);
    issue(op, 3'h0, 7'h20, b);
    check(32'(n_d), 32'd2, "sub cycles");
    rd_chk(OFS_FLAGS, fl, "sub flags");
    rd_chk(OFS_ACC, {24'h0, (op == 3'h5) ? a : d}, "sub acc");
    mem_chk(7'h20, (op == 3'h5) ? d : b, "sub mem");
  endtask : sub_case

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc_q++;
    if (cyc_q > 20000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int cnt; // expected dropped-instruction count
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_chk(OFS_ACC, 32'h0, "reset acc");
    rd_chk(OFS_STATUS, 32'h0, "reset status");
    $display("test reset done");
    // memory increment wraps to zero, skip, flags kept, next op dropped
    bus(1'b1, OFS_FLAGS, 32'h0000000A);
    set_mem(7'h05, 8'hFF);
    issue(3'h1, 3'h0, 7'h05, 8'h00);
    check(32'(n_d), 32'd3, "skip cycles");
    mem_chk(7'h05, 8'h00, "inc mem");
    rd_chk(OFS_STATUS, 32'h2, "skip pending");
    issue(3'h6, 3'h0, 7'h00, 8'h55);
    check(32'(n_d), 32'd1, "drop cycles");
    rd_chk(OFS_ACC, 32'h0, "dropped acc");
    rd_chk(OFS_FLAGS, 32'hA, "flags kept");
    rd_chk(OFS_STATUS, 32'h100, "drop count");
    rd_chk(OFS_INSTR, 32'h0060_0055, "dropped word");
    set_mem(7'h06, 8'h10);
    issue(3'h1, 3'h0, 7'h06, 8'h00);
    check(32'(n_d), 32'd2, "no skip cycles");
    mem_chk(7'h06, 8'h11, "inc mem");
    $display("test memory increment done");
    // increment into accumulator, memory kept
    set_mem(7'h07, 8'hFF);
    issue(3'h2, 3'h0, 7'h07, 8'h00);
    check(32'(n_d), 32'd3, "skip cycles");
    rd_chk(OFS_ACC, 32'h0, "inc acc");
    mem_chk(7'h07, 8'hFF, "mem kept");
    issue(3'h0, 3'h0, 7'h00, 8'h00);
    rd_chk(OFS_STATUS, 32'h200, "drop count");
    set_mem(7'h08, 8'h41);
    issue(3'h2, 3'h0, 7'h08, 8'h00);
    rd_chk(OFS_ACC, 32'h42, "inc acc");
    issue(3'h7, 3'h0, 7'h08, 8'h00);
    check(32'(n_d), 32'd2, "spare op cycles");
    rd_chk(OFS_ACC, 32'h42, "spare op acc");
    $display("test accumulator increment done");
    // every bit position of a mixed byte
    set_mem(7'h09, bit_pat);
    cnt = 2;
    for (int i = 0; i < 8; i++) begin
      issue(3'h3, i[2:0], 7'h09, 8'h00);
      check(32'(n_d), 32'd2 + {31'h0, bit_pat[i]}, "bit cycles");
      rd_chk(OFS_STATUS, {16'h0, cnt[7:0], 6'h0, bit_pat[i], 1'b0}, "bit skip");
      if (bit_pat[i]) begin
        issue(3'h0, 3'h0, 7'h00, 8'h00);
        cnt++;
      end
    end
    $display("test bit skip done");
    // three subtract forms over the flag corner cases
    for (int op = 4; op < 7; op++) begin
      for (int k = 0; k < 5; k++) sub_case(op[2:0], ca[k], cb[k]);
    end
    $display("test subtract done");
    // unmapped place: write ignored, read zero
    bus(1'b1, 5'h1C, 32'hFFFFFFFF);
    rd_chk(5'h1C, 32'h0, "unmapped");
    $display("test unmapped done");
    close_out();
  end
endmodule : test_skip_and_subtract_exec
